// ---- rtl/sasd_servo_alarm_status_decode.v ----
// Servo alarm status decode, feedback scaling and dogless reference logic
//
// Notes on behaviour
// - Alarm byte one holds eight amplifier flags
// - Disconnect, select 1, external 0: built-in hardware
// - Disconnect, select 1, external 1: separate hardware
// - Disconnect, select 0, external 0: software detected
// - Coder hardware fault sets coder bit 6
// - Low battery sets warning bit 5 only
// - Zero battery sets bit 2, voids reference
// - Coder internal halt sets bit 1
// - Feedback count error sets bit 4
// - Feedback count error sets bit 0
// - Count fault with all three set: count miss
// - No coder response sets link bit 7
// - Bad data sets check bit 6, frame 5
// - Coder C pulses 4000, full loop NS/10
// - Reference mode jog stops at next grid
// - Stop grid position becomes reference position
// - Home mode plus jog returns to reference
// - Home mode direction follows configured parameter
// - Absolute detector keeps reference over power-off; here reset clears it whether abs_det is set or not
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "sasd_defs.vh"

module sasd_servo_alarm_status_decode #(
    parameter POS_W = 32
) (
    input wire mclk, // System clock
    input wire rst, // Asynchronous reset, active high
    input wire [3:0] bus_addr, // Register address
    input wire [7:0] bus_wdata, // Write data
    input wire bus_wr, // Write strobe
    input wire bus_rd, // Read strobe
    output reg [7:0] bus_rdata, // Read data, cycle after strobe
    input wire [7:0] amp_alarm_in, // Amplifier alarm flags, bit7..0
    input wire location_select_in, // Disconnection location select
    input wire external_hw_in, // External hardware disconnection
    input wire [6:0] coder_alarm_in, // Coder flags, bit6..0
    input wire no_response_in, // Coder gave no response
    input wire check_code_err_in, // Coder check code failure
    input wire frame_err_in, // Coder frame failure
    input wire [3:0] misc_alarm_in, // Misc servo flags, bit6..3
    input wire [15:0] quad_feedback_pulses, // Scale pulses times four
    input wire axis_dir_plus, // Axis direction plus button
    input wire axis_dir_minus, // Axis direction minus button
    input wire grid_pulse, // Grid point marker from coder
    input wire [POS_W-1:0] axis_position, // Present axis position
    output reg axis_move_en, // Axis feed request
    output reg axis_move_neg, // Feed direction, 1 is negative
    output reg [POS_W-1:0] home_target, // Target for home return
    output reg [15:0] vel_pulses, // Velocity feedback pulse count
    output reg [15:0] pos_pulses, // Position feedback pulse count
    output reg count_miss_alarm, // Count miss condition
    output reg stop_alarm // Any stopping alarm active
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam SYN_W = 8 + 2 + 7 + 3 + 4 + 3;
    wire [SYN_W-1:0] raw_in;
    reg [SYN_W-1:0] sync1_reg;
    reg [SYN_W-1:0] sync2_reg;
    assign raw_in = {amp_alarm_in, location_select_in, external_hw_in, coder_alarm_in,
                     no_response_in, check_code_err_in, frame_err_in, misc_alarm_in,
                     axis_dir_plus, axis_dir_minus, grid_pulse};

    // Two stages on every pin packed in raw_in (bus pins are not synchronised); only stage two is read
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_reg <= {SYN_W{1'b0}};
            sync2_reg <= {SYN_W{1'b0}};
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Stage two slices, in the order that raw_in packs them
    wire [7:0] s_amp = sync2_reg[SYN_W-1 -: 8];
    wire s_loc = sync2_reg[18];
    wire s_ext = sync2_reg[17];
    wire [6:0] s_coder = sync2_reg[16:10];
    wire s_noresp = sync2_reg[9];
    wire s_chk = sync2_reg[8];
    wire s_frm = sync2_reg[7];
    wire [3:0] s_misc = sync2_reg[6:3];
    wire s_plus = sync2_reg[2];
    wire s_minus = sync2_reg[1];
    wire s_grid = sync2_reg[0];
    wire jog_req = s_plus | s_minus;

    // ----------------------------------------------------------------
    // Word input synchronisers
    // ----------------------------------------------------------------
    // Position and scale words take the same two stages as the flags, so a
    // grid marker and the position it belongs to reach the logic together.
    // Limitation: a word caught while it changes may be off for one cycle.
    reg [POS_W-1:0] pos_sync1_reg;
    reg [POS_W-1:0] pos_sync2_reg;
    reg [15:0] quad_sync1_reg;
    reg [15:0] quad_sync2_reg;

    // Two stages on each word
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pos_sync1_reg <= {POS_W{1'b0}};
            pos_sync2_reg <= {POS_W{1'b0}};
            quad_sync1_reg <= 16'h0000;
            quad_sync2_reg <= 16'h0000;
        end else begin
            pos_sync1_reg <= axis_position;
            pos_sync2_reg <= pos_sync1_reg;
            quad_sync1_reg <= quad_feedback_pulses;
            quad_sync2_reg <= quad_sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Sticky alarm bytes
    // ----------------------------------------------------------------
    reg [7:0] alarm1_reg;
    reg [7:0] alarm2_reg;
    reg [7:0] coder_reg;
    reg [7:0] link_reg;
    reg [7:0] misc_reg;
    reg [7:0] clr_mask;
    reg [4:0] clr_sel;
    wire clear_wr = bus_wr && (bus_addr == `SASD_OFS_CLEAR);

    // Write-one-to-clear; a flag raised in the same cycle survives
    always @* begin
        clr_mask = clear_wr ? bus_wdata : 8'h00;
        clr_sel = 5'h00;
        if (clear_wr) begin
            clr_sel = 5'h1f;
        end
    end

    wire [7:0] amp_set = s_amp;
    wire [7:0] a2_set = {s_loc, 2'b00, s_ext, 4'h0};
    wire [7:0] coder_set = {1'b0, s_coder};
    wire [7:0] link_set = {s_noresp, s_chk, s_frm, 5'h00};
    wire [7:0] misc_set = {1'b0, s_misc, 3'h0};

    // Sticky bytes, set over clear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            alarm1_reg <= 8'h00;
            alarm2_reg <= 8'h00;
            coder_reg <= 8'h00;
            link_reg <= 8'h00;
            misc_reg <= 8'h00;
        end else begin
            alarm1_reg <= amp_set | (alarm1_reg & ~(clr_mask & {8{clr_sel[0]}}));
            alarm2_reg <= a2_set | (alarm2_reg & ~(clr_mask & {8{clr_sel[1]}}));
            coder_reg <= coder_set | (coder_reg & ~(clr_mask & {8{clr_sel[2]}}));
            link_reg <= link_set | (link_reg & ~(clr_mask & {8{clr_sel[3]}}));
            misc_reg <= misc_set | (misc_reg & ~(clr_mask & {8{clr_sel[4]}}));
        end
    end

    // ----------------------------------------------------------------
    // Disconnection cause and count miss decode
    // ----------------------------------------------------------------
    // Decode reads the sticky bytes, so a cause outlives its pin
    wire fb_disc = alarm1_reg[`SASD_A1_FB_DISC];
    wire loc_sel = alarm2_reg[`SASD_A2_LOC_SEL];
    wire ext_hw = alarm2_reg[`SASD_A2_EXT_HW];
    wire dec_builtin = fb_disc & loc_sel & ~ext_hw;
    wire dec_separate = fb_disc & loc_sel & ext_hw;
    wire dec_software = fb_disc & ~loc_sel & ~ext_hw;
    wire cnt_miss = coder_reg[`SASD_C_CNT_FAULT] & fb_disc & loc_sel & ext_hw;
    // Low battery is a warning, so it is left out of the stop summary
    wire stop_next = (|alarm1_reg) | (|(coder_reg & 8'h5f)) | (|link_reg)
                     | (|misc_reg);

    // ----------------------------------------------------------------
    // Control register and feedback scaling
    // ----------------------------------------------------------------
    reg [7:0] ctrl_reg;
    wire ref_mode = ctrl_reg[`SASD_CTRL_REF_MODE];
    wire home_mode = ctrl_reg[`SASD_CTRL_HOME_MODE];
    wire full_loop = ctrl_reg[`SASD_CTRL_FULL_LOOP];
    wire dir_neg_cfg = ctrl_reg[`SASD_CTRL_DIR_NEG];
    wire abs_det = ctrl_reg[`SASD_CTRL_ABS_DET];

    // Control bits; invalidate is a self-clearing command
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `SASD_CTRL_RESET;
        end else if (bus_wr && (bus_addr == `SASD_OFS_CTRL)) begin
            ctrl_reg <= bus_wdata;
        end else begin
            ctrl_reg[`SASD_CTRL_INVALIDATE] <= 1'b0;
        end
    end

    // Coder C scaling; division is slow but the inputs are static
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            vel_pulses <= 16'h0000;
            pos_pulses <= 16'h0000;
        end else begin
            // Velocity count is fixed for this coder in either loop
            vel_pulses <= `SASD_SEMI_PULSES;
            pos_pulses <= full_loop ? (quad_sync2_reg / `SASD_FULL_DIV)
                                    : `SASD_SEMI_PULSES;
        end
    end

    // ----------------------------------------------------------------
    // Dogless reference setting and home return
    // ----------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_SEEK = 4'b0010;
    localparam ST_HOME = 4'b0100;
    localparam ST_WAIT = 4'b1000;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [POS_W-1:0] ref_pos_reg;
    reg ref_valid_reg;
    reg dir_reg;
    // Stops once the synchronised position matches; the axis coasts a few
    // counts past, which the drive's own position loop takes back
    wire at_home = (pos_sync2_reg == ref_pos_reg);

    // Next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (home_mode && ref_valid_reg && jog_req) begin
                    state_next = ST_HOME;
                end else if (ref_mode && !home_mode && jog_req) begin
                    state_next = ST_SEEK;
                end
            end
            ST_SEEK: begin
                if (s_grid) begin
                    state_next = ST_WAIT;
                end
            end
            ST_HOME: begin
                if (at_home) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Wait for button release so one press gives one move
                if (!jog_req) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Sequencer and stored reference
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            ref_pos_reg <= {POS_W{1'b0}};
            ref_valid_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE) begin
                // Home return ignores the button direction
                dir_reg <= home_mode ? dir_neg_cfg : s_minus;
            end
            if (state_reg == ST_SEEK && s_grid) begin
                // Marker and position are both two stages old, so they agree
                ref_pos_reg <= pos_sync2_reg;
                ref_valid_reg <= 1'b1;
            end else if (coder_reg[`SASD_C_BATT_ZERO] || ctrl_reg[`SASD_CTRL_INVALIDATE]
                         || !abs_det) begin
                // Without absolute detector the reference holds outside idle; otherwise loss voids it
                if (!abs_det && state_reg != ST_IDLE) begin
                    ref_valid_reg <= ref_valid_reg;
                end else if (coder_reg[`SASD_C_BATT_ZERO]
                             || ctrl_reg[`SASD_CTRL_INVALIDATE]) begin
                    ref_valid_reg <= 1'b0;
                end
            end
        end
    end

    // Registered outputs
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            axis_move_en <= 1'b0;
            axis_move_neg <= 1'b0;
            home_target <= {POS_W{1'b0}};
            count_miss_alarm <= 1'b0;
            stop_alarm <= 1'b0;
        end else begin
            axis_move_en <= (state_next == ST_SEEK) || (state_next == ST_HOME);
            axis_move_neg <= (state_reg == ST_IDLE) ? (home_mode ? dir_neg_cfg : s_minus)
                                                     : dir_reg;
            home_target <= ref_pos_reg;
            count_miss_alarm <= cnt_miss;
            stop_alarm <= stop_next;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    wire [7:0] decode_byte = {1'b0, state_reg == ST_SEEK, state_reg == ST_HOME, ref_valid_reg,
                              cnt_miss, dec_software, dec_separate, dec_builtin};
    reg [7:0] rd_mux;

    // Unmapped addresses read zero
    always @* begin
        case (bus_addr)
            `SASD_OFS_ALARM1: rd_mux = alarm1_reg;
            `SASD_OFS_ALARM2: rd_mux = alarm2_reg;
            `SASD_OFS_CODER: rd_mux = coder_reg;
            `SASD_OFS_LINK: rd_mux = link_reg;
            `SASD_OFS_MISC: rd_mux = misc_reg;
            `SASD_OFS_DECODE: rd_mux = decode_byte;
            `SASD_OFS_CTRL: rd_mux = ctrl_reg;
            `SASD_OFS_PULSE: rd_mux = pos_pulses[7:0];
            `SASD_OFS_REFPOS_LO: rd_mux = ref_pos_reg[7:0];
            `SASD_OFS_REFPOS_HI: rd_mux = ref_pos_reg[15:8];
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else begin
            bus_rdata <= bus_rd ? rd_mux : 8'h00;
        end
    end

endmodule // sasd_servo_alarm_status_decode

// ---- pkg/sasd_defs.vh ----
// Constants for the servo alarm status decode block
`ifndef SASD_DEFS_VH
`define SASD_DEFS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SASD_OFS_ALARM1 4'h0
`define SASD_OFS_ALARM2 4'h1
`define SASD_OFS_CODER 4'h2
`define SASD_OFS_LINK 4'h3
`define SASD_OFS_MISC 4'h4
`define SASD_OFS_DECODE 4'h5
`define SASD_OFS_CTRL 4'h6
`define SASD_OFS_PULSE 4'h7
`define SASD_OFS_REFPOS_LO 4'h8
`define SASD_OFS_REFPOS_HI 4'h9
`define SASD_OFS_CLEAR 4'ha
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SASD_A1_OVERLOAD 7
`define SASD_A1_LOW_VOLT 6
`define SASD_A1_OVERCUR 5
`define SASD_A1_ABN_CUR 4
`define SASD_A1_EXC_VOLT 3
`define SASD_A1_DISCHARGE 2
`define SASD_A1_FB_DISC 1
`define SASD_A1_OVERFLOW 0
`define SASD_A2_LOC_SEL 7
`define SASD_A2_EXT_HW 4
`define SASD_C_HW_FAULT 6
`define SASD_C_BATT_LOW 5
`define SASD_C_CNT_ERR_A 4
`define SASD_C_CNT_FAULT 3
`define SASD_C_BATT_ZERO 2
`define SASD_C_HALTED 1
`define SASD_C_CNT_ERR_B 0
`define SASD_L_NO_RESP 7
`define SASD_L_CHECK_ERR 6
`define SASD_L_FRAME_ERR 5
`define SASD_D_BUILTIN_HW 0
`define SASD_D_SEPARATE_HW 1
`define SASD_D_SOFTWARE 2
`define SASD_D_COUNT_MISS 3
`define SASD_D_REF_VALID 4
`define SASD_D_HOMING 5
`define SASD_D_SETTING 6
`define SASD_CTRL_REF_MODE 0
`define SASD_CTRL_HOME_MODE 1
`define SASD_CTRL_FULL_LOOP 2
`define SASD_CTRL_DIR_NEG 3
`define SASD_CTRL_ABS_DET 4
`define SASD_CTRL_INVALIDATE 5
// ----------------------------------------------------------------
// Reset values and scaling
// ----------------------------------------------------------------
`define SASD_CTRL_RESET 8'h00
`define SASD_SEMI_PULSES 16'hfa0
`define SASD_FULL_DIV 16'h000a
`define SASD_QUAD_MUL 4
`endif

// ---- verif/sasd_servo_alarm_status_decode_props.sv ----
// Property checker for the servo alarm status decode block
`timescale 1ns/1ps
`include "sasd_defs.vh"
module sasd_props (
    input wire mclk, // Clock
    input wire rst, // Reset, active high
    input wire [3:0] bus_addr, // Address
    input wire [7:0] bus_wdata, // Write data
    input wire bus_wr, // Write strobe
    input wire bus_rd, // Read strobe
    input wire [7:0] bus_rdata, // Read data
    input wire [7:0] amp_alarm_in, // Amplifier flags
    input wire location_select_in, // Location select
    input wire external_hw_in, // External hardware
    input wire [6:0] coder_alarm_in, // Coder flags
    input wire no_response_in, // No response
    input wire check_code_err_in, // Check code failure
    input wire frame_err_in, // Frame failure
    input wire [3:0] misc_alarm_in, // Misc flags
    input wire [15:0] quad_feedback_pulses, // Scale pulses times four
    input wire grid_pulse, // Grid marker
    input wire axis_move_en, // Feed request
    input wire axis_move_neg, // Feed direction
    input wire [15:0] vel_pulses, // Velocity pulses
    input wire [15:0] pos_pulses, // Position pulses
    input wire count_miss_alarm, // Count miss
    input wire stop_alarm // Stopping alarm
);
// ----------------------------------------------------------------
// Helper state and properties
// ----------------------------------------------------------------
default clocking cb @(posedge mclk); endclocking
default disable iff (rst);
reg [2:0] up_cnt;
reg [7:0] ctrl_seen;
wire only_batt;
// Only the battery warning is present, nothing that should stop
assign only_batt = amp_alarm_in == 8'h00 && coder_alarm_in == 7'h20 && misc_alarm_in == 4'h0
    && !no_response_in && !check_code_err_in && !frame_err_in && !location_select_in
    && !external_hw_in;
// Settling count after reset, so pipelines fill before outputs are judged
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        up_cnt <= 3'h0;
        ctrl_seen <= 8'h00;
    end else begin
        if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
        if (bus_wr && bus_addr == `SASD_OFS_CTRL) ctrl_seen <= bus_wdata;
    end
end
a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside an answer");
a_read_unmapped: assert property (bus_rd && bus_addr > `SASD_OFS_CLEAR |=> bus_rdata == 8'h00)
    else $error("unmapped read returned data");
a_overload_bit: assert property ((amp_alarm_in[7] [*4] ##0 (bus_rd && bus_addr == 4'h0))
    |=> bus_rdata[7]) else $error("overload flag not in bit 7");
a_count_miss: assert property (amp_alarm_in[1] && location_select_in && external_hw_in
    && coder_alarm_in[3] |-> ##[2:5] count_miss_alarm) else $error("count miss not raised");
a_stop_raise: assert property (amp_alarm_in != 8'h00 || coder_alarm_in[6] || no_response_in
    |-> ##[2:5] stop_alarm) else $error("stop alarm not raised");
a_batt_warn: assert property ((only_batt [*5] ##0 !stop_alarm) |=> !stop_alarm)
    else $error("battery warning stopped the axis");
a_grid_stop: assert property (axis_move_en && ctrl_seen[0] && !ctrl_seen[1] && grid_pulse
    |-> ##[1:4] !axis_move_en) else $error("move did not stop at grid");
a_home_dir: assert property (axis_move_en && ctrl_seen[1] |-> axis_move_neg == ctrl_seen[3])
    else $error("home feed ignores direction setting");
a_vel_const: assert property (up_cnt == 3'h7 |-> vel_pulses == `SASD_SEMI_PULSES)
    else $error("velocity pulses wrong");
a_pos_semi: assert property ((up_cnt == 3'h7 && !ctrl_seen[2]) [*4]
    |-> pos_pulses == `SASD_SEMI_PULSES) else $error("semi loop pulses wrong");
a_pos_full: assert property ((up_cnt == 3'h7 && ctrl_seen[2]) [*4]
    |-> pos_pulses == quad_feedback_pulses / `SASD_FULL_DIV) else $error("full loop pulses wrong");
endmodule // sasd_props

bind sasd_servo_alarm_status_decode sasd_props u_props (
    .mclk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .amp_alarm_in,
    .location_select_in, .external_hw_in, .coder_alarm_in, .no_response_in, .check_code_err_in,
    .frame_err_in, .misc_alarm_in, .quad_feedback_pulses, .grid_pulse, .axis_move_en,
    .axis_move_neg, .vel_pulses, .pos_pulses, .count_miss_alarm, .stop_alarm
);

// ---- verif/sasd_coder_model.sv ----
// Behavioural model of the pulse coder and axis drive
`timescale 1ns/1ps
module sasd_coder_model #(
    parameter POS_W = 32,
    parameter [31:0] START_POS = 32'h0000_1234
) (
    input wire mclk, // Clock
    input wire rst, // Reset, active high
    input wire move_en, // Feed request
    input wire move_neg, // Feed direction, 1 is negative
    output reg [POS_W-1:0] position, // Axis position
    output wire grid_mark // Grid marker
);
// ----------------------------------------------------------------
// Axis motion, one count a cycle
// ----------------------------------------------------------------
// Marker stays high while parked on a grid point, as a real coder would
assign grid_mark = position[3:0] == 4'h0;
// Position keeps moving until the block drops its request
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        position <= START_POS[POS_W-1:0];
    end else if (move_en) begin
        position <= move_neg ? position - 1'b1 : position + 1'b1;
    end
end
endmodule // sasd_coder_model

// ---- verif/sasd_servo_alarm_status_decode_tb_top.sv ----
// Self-checking bench for the servo alarm status decode block
`timescale 1ns/1ps
`include "sasd_defs.vh"
module sasd_servo_alarm_status_decode_tb_top;
localparam [31:0] START = 32'h0000_1234;
reg mclk, rst, bus_wr, bus_rd, location_select_in, external_hw_in, no_response_in;
reg check_code_err_in, frame_err_in, axis_dir_plus, axis_dir_minus;
reg [3:0] bus_addr, misc_alarm_in;
reg [7:0] bus_wdata, amp_alarm_in;
reg [6:0] coder_alarm_in;
reg [15:0] quad_feedback_pulses;
wire [7:0] bus_rdata;
wire [31:0] axis_position, home_target;
wire [15:0] vel_pulses, pos_pulses;
wire grid_pulse, axis_move_en, axis_move_neg, count_miss_alarm, stop_alarm;
integer num_errors, n_compared, seed, i, n, a1, a2, c, l, m, d, r;
sasd_servo_alarm_status_decode u_dut (
    .mclk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .amp_alarm_in,
    .location_select_in, .external_hw_in, .coder_alarm_in, .no_response_in, .check_code_err_in,
    .frame_err_in, .misc_alarm_in, .quad_feedback_pulses, .axis_dir_plus, .axis_dir_minus,
    .grid_pulse, .axis_position, .axis_move_en, .axis_move_neg, .home_target, .vel_pulses,
    .pos_pulses, .count_miss_alarm, .stop_alarm
);
sasd_coder_model #(.START_POS(START)) u_coder (.mclk(mclk), .rst(rst), .move_en(axis_move_en),
    .move_neg(axis_move_neg), .position(axis_position), .grid_mark(grid_pulse));
// ----------------------------------------------------------------
// Clock, watchdog and shared tasks
// ----------------------------------------------------------------
initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end
// Tests need under 300 cycles; a hang is cut well beyond that
initial begin
    repeat (20000) @(posedge mclk);
    num_errors = num_errors + 1;
    end_sim;
end
task end_sim;
begin
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
end
endtask
task chk(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
    end
end
endtask
task wr(input [3:0] a, input [7:0] v);
begin
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'b0;
end
endtask
// Data stand only in the cycle after the strobe, so look there
task rd(input [3:0] a, input [31:0] e, input [8*8-1:0] what);
begin
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk(what, e, {24'h0, bus_rdata});
end
endtask
task drv(input [31:0] x1, input [31:0] x2, input [31:0] xc, input [31:0] xl, input [31:0] xm);
begin
    @(posedge mclk);
    amp_alarm_in <= x1[7:0];
    location_select_in <= x2[7];
    external_hw_in <= x2[4];
    coder_alarm_in <= xc[6:0];
    {no_response_in, check_code_err_in, frame_err_in} <= xl[7:5];
    misc_alarm_in <= xm[6:3];
end
endtask
task wmv(input v);
begin
    n = 0;
    while (axis_move_en !== v && n < 60) begin
        @(posedge mclk);
        #1;
        n = n + 1;
    end
    chk("move_en", v, axis_move_en);
end
endtask
// ----------------------------------------------------------------
// Test sequence
// ----------------------------------------------------------------
initial begin
    {num_errors, n_compared, seed} = {32'd0, 32'd0, 32'd91797};
    {rst, bus_wr, bus_rd, bus_addr, bus_wdata, axis_dir_plus, axis_dir_minus} = 17'h10000;
    {amp_alarm_in, location_select_in, external_hw_in, coder_alarm_in} = 17'h0;
    {no_response_in, check_code_err_in, frame_err_in, misc_alarm_in} = 7'h0;
    // Host keeps coder C type bits and motor model; only the scale is ours
    quad_feedback_pulses = 16'h1f40; // Scale of 2000 pulses, times four
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
        rd(i[3:0], (i == 7) ? 8'ha0 : 0, "reset");
    end
    $display("test reset done");
    // Every disconnection cause, then a battery warning by itself
    for (i = 0; i < 5; i = i + 1) begin
        a1 = (i < 4) ? ($random(seed) & 255) | 130 : 0;
        a2 = (i < 4) ? ((i & 2) << 6) | ((i & 1) << 4) : 0;
        c = (i < 4) ? ($random(seed) & 127) | ((i == 3) << 3) : 32;
        l = (i < 4) ? ($random(seed) & 7) << 5 : 0;
        m = (i < 4) ? ($random(seed) & 15) << 3 : 0;
        d = (a1[1] & a2[7] & !a2[4]) | ((a1[1] & a2[7] & a2[4]) << 1)
            | ((a1[1] & !a2[7] & !a2[4]) << 2) | ((a1[1] & a2[7] & a2[4] & c[3]) << 3);
        drv(a1, a2, c, l, m);
        repeat (6) @(posedge mclk);
        #1;
        chk("stop", i < 4, stop_alarm);
        chk("count_miss_alarm", i == 3, count_miss_alarm);
        rd(`SASD_OFS_ALARM1, a1, "alarm1");
        wr(`SASD_OFS_ALARM1, 8'h00);
        drv(0, 0, 0, 0, 0);
        repeat (5) @(posedge mclk);
        rd(`SASD_OFS_ALARM1, a1, "alarm1");
        rd(`SASD_OFS_ALARM2, a2, "alarm2");
        rd(`SASD_OFS_CODER, c, "coder");
        rd(`SASD_OFS_LINK, l, "link");
        rd(`SASD_OFS_MISC, m, "misc");
        rd(`SASD_OFS_DECODE, d, "decode");
        wr(`SASD_OFS_CLEAR, 8'hff);
        rd(`SASD_OFS_DECODE, 0, "decode");
        rd(`SASD_OFS_ALARM1, 0, "alarm1");
        #1;
        chk("stop", 0, stop_alarm);
    end
    $display("test alarms done");
    chk("vel", 16'hfa0, vel_pulses);
    chk("pos", 16'hfa0, pos_pulses);
    wr(`SASD_OFS_CTRL, 8'h04);
    repeat (4) @(posedge mclk);
    #1;
    chk("pos", 16'h1f40 / 10, pos_pulses);
    chk("vel", 16'hfa0, vel_pulses);
    rd(`SASD_OFS_PULSE, (16'h1f40 / 10) & 255, "pulse");
    rd(`SASD_OFS_CTRL, 8'h04, "ctrl");
    $display("test pulses done");
    // Dogless setting: jog negative from an off-grid spot
    r = START & 32'hfffffff0;
    wr(`SASD_OFS_CTRL, 8'h01);
    @(posedge mclk);
    axis_dir_minus <= 1'b1;
    wmv(1'b1);
    chk("neg", 1, axis_move_neg);
    wmv(1'b0);
    @(posedge mclk);
    axis_dir_minus <= 1'b0;
    rd(`SASD_OFS_REFPOS_LO, r & 255, "ref_lo");
    rd(`SASD_OFS_REFPOS_HI, (r >> 8) & 255, "ref_hi");
    rd(`SASD_OFS_DECODE, 8'h10, "decode");
    $display("test dogless done");
    // Home return: the minus button is pressed but the setting says plus
    wr(`SASD_OFS_CTRL, 8'h02);
    @(posedge mclk);
    axis_dir_minus <= 1'b1;
    wmv(1'b1);
    chk("neg", 0, axis_move_neg);
    chk("target", r, home_target);
    wmv(1'b0);
    @(posedge mclk);
    axis_dir_minus <= 1'b0;
    $display("test home done");
    // Battery at zero voids the stored reference
    drv(0, 0, 4, 0, 0);
    drv(0, 0, 0, 0, 0);
    repeat (5) @(posedge mclk);
    rd(`SASD_OFS_CODER, 8'h04, "coder");
    rd(`SASD_OFS_DECODE, 8'h00, "decode");
    $display("test battery done");
    end_sim;
end
endmodule // sasd_servo_alarm_status_decode_tb_top
